// ==== hdl/qra_pkg.sv ====
// package of constants and types for the quadrature rotor angle block
`default_nettype none
package qra_pkg;
  // apb register byte offsets
  localparam logic [7:0] ADDR_CAPCTL = 8'h00;
  localparam logic [7:0] ADDR_TIMCON = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_COUNT  = 8'h0c;
  localparam logic [7:0] ADDR_IDXCNT = 8'h10;
  localparam logic [7:0] ADDR_THETA  = 8'h14;
  localparam logic [7:0] ADDR_FLAGS  = 8'h18;
  // field positions
  localparam int CAP_EN_LO   = 13;
  localparam int CAP_EN_HI   = 14;
  localparam int DIR_BIT     = 14;
  localparam int CFG_PP_LSB  = 0;
  localparam int CFG_PP_W    = 8;
  localparam int FLG_DIR_LSB = 4;
  // values
  localparam logic [3:0]  FLAG_SET      = 4'hf;
  localparam logic [3:0]  FLAG_CLR      = 4'h0;
  localparam logic [15:0] ANGLE_MASK    = 16'h7fff;
  localparam int          Q26_SHIFT     = 26;
  localparam int          Q15_SHIFT     = 15;
  localparam logic [7:0]  POLE_PAIRS_RST = 8'h01;
  localparam int          COUNTS_PER_REV = 4000;
  localparam int          MECH_SCALE_Q26 = 16777;
  localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;
  typedef enum logic [1:0] {QRA_IDLE, QRA_CALC, QRA_DONE} qra_calc_e;
endpackage : qra_pkg
`default_nettype wire

// ==== hdl/qra_edge_if.sv ====
// interface carrying decoded counter events between the decoder and the top
`timescale 1ns/1ps
`default_nettype none
interface qra_edge_if;
  logic count_pulse;
  logic count_up;
  logic index_rise;
  modport source (output count_pulse, output count_up, output index_rise);
  modport sink   (input count_pulse, input count_up, input index_rise);
endinterface : qra_edge_if
`default_nettype wire

// ==== hdl/qra_decoder.sv ====
// quadrature and index edge decoder
`timescale 1ns/1ps
`default_nettype none
module qra_decoder (
  input  wire logic  clock,
  input  wire logic  nrst,
  input  wire logic  ce,
  input  wire logic  enable,
  input  wire logic  quad_pin_first,
  input  wire logic  quad_pin_second,
  input  wire logic  index_pin,
  qra_edge_if.source ev
);
  logic a_reg, b_reg, i_reg;
  logic pulse_reg, up_reg, irise_reg;
  logic pulse_next, up_next, irise_next;

  always_comb begin
    pulse_next = 1'b0;
    up_next    = up_reg;
    irise_next = index_pin & ~i_reg;
    // while enabled, any edge of either input gives one count
    if (enable && ((quad_pin_first ^ a_reg) || (quad_pin_second ^ b_reg))) begin
      pulse_next = 1'b1; // [R1] [R4]
      // first leads second: up; else down
      up_next = ((quad_pin_first ^ a_reg) ? (quad_pin_first ^ b_reg) : ~(quad_pin_second ^ a_reg)); // [R3]
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      a_reg     <= 1'b0;
      b_reg     <= 1'b0;
      i_reg     <= 1'b0;
      pulse_reg <= 1'b0;
      up_reg    <= 1'b1;
      irise_reg <= 1'b0;
    end else if (ce) begin
      a_reg     <= quad_pin_first;
      b_reg     <= quad_pin_second;
      i_reg     <= index_pin;
      pulse_reg <= pulse_next;
      up_reg    <= up_next;
      irise_reg <= irise_next;
    end
  end

  assign ev.count_pulse = pulse_reg;
  assign ev.count_up    = up_reg;
  assign ev.index_rise  = irise_reg; // [R6]
endmodule : qra_decoder
`default_nettype wire

// ==== hdl/qra_top.sv ====
// quadrature rotor angle block with apb registers
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
//
// Operation
// R1 - a count pulse is made on every rising and falling edge of both quadrature inputs.
// R2 - each count pulse advances the position counter once; a pulse in the same cycle as an index event is dropped.
// R3 - the decoded direction sets whether the counter counts up or down.
// R4 - decoding happens only while capture control bits 13 and 14 are set; index edges are decoded whatever these bits hold.
// R5 - the counting direction reads as bit 14 of the timer control register.
// R6 - each rising edge of the index input makes an index event.
// R7 - an index event clears the counter and sets the sync flag to f.
// R8 - the counter value is saved into count-at-index before it is cleared.
// R9 - the counter is sampled into a raw angle count.
// R10 - counts per revolution is a parameter with default 4000.
// R11 - mechanical angle is raw count times a q26 scale, default 16777.
// R12 - electrical angle is pole pairs times mechanical angle.
// R13 - both angles are q15 values from 0 to 7fff.
// R14 - direction is reported as 0 or f.
// R15 - the encoder drives a, b and index onto the first, second and index inputs.
// R16 - the count is referenced to the encoder zero after the first index.
// R17 - counter, sync flag and saved count are zero after reset.
module qra_top #(
  parameter int          COUNTS_PER_REV = qra_pkg::COUNTS_PER_REV, // [R10]
  parameter logic [15:0] MECH_SCALE     = 16'(qra_pkg::MECH_SCALE_Q26), // [R11]
  parameter int          CNT_W          = 16
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        quad_pin_first,
  input  wire logic        quad_pin_second,
  input  wire logic        index_pin,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [15:0] theta_mech,
  output logic      [15:0] theta_elec,
  output logic      [3:0]  dir_flag,
  output logic      [3:0]  index_sync_flag,
  output logic      [CNT_W-1:0] count_at_index
);
  qra_edge_if ev ();

  logic [15:0]      capctl_reg, capctl_next;
  logic [7:0]       pp_reg, pp_next;
  logic [CNT_W-1:0] position_counter, position_counter_next;
  logic [CNT_W-1:0] idx_reg, idx_next;
  logic [3:0]       sync_reg, sync_next;
  logic [CNT_W-1:0] raw_reg, raw_next;
  logic [15:0]      mech_reg, mech_next;
  logic [15:0]      elec_reg, elec_next;
  logic [3:0]       dir_reg, dir_next;
  logic [31:0]      prdata_next;
  logic             pready_next, pslverr_next;
  logic             dec_en;
  logic [CNT_W+15:0] mech_prod;
  logic [23:0]       elec_prod;

  assign dec_en = capctl_reg[qra_pkg::CAP_EN_LO] & capctl_reg[qra_pkg::CAP_EN_HI]; // [R4]

  // pins wired a to first, b to second, index to index input [R15]
  qra_decoder u_dec (
    .clock           (clock),
    .nrst            (nrst),
    .ce              (ce),
    .enable          (dec_en),
    .quad_pin_first  (quad_pin_first),
    .quad_pin_second (quad_pin_second),
    .index_pin       (index_pin),
    .ev              (ev.source)
  );

  // position counter and index handling
  always_comb begin
    position_counter_next = position_counter;
    idx_next  = idx_reg;
    sync_next = sync_reg;
    if (ev.index_rise) begin
      idx_next              = position_counter; // [R8]
      position_counter_next = '0; // [R7] [R16]
      sync_next             = qra_pkg::FLAG_SET; // [R7]
    end else if (ev.count_pulse) begin
      if (ev.count_up) begin // [R3]
        position_counter_next = (position_counter == CNT_W'(COUNTS_PER_REV - 1)) ? '0
                                : position_counter + 1'b1; // [R2]
      end else begin
        position_counter_next = (position_counter == '0) ? CNT_W'(COUNTS_PER_REV - 1)
                                : position_counter - 1'b1; // [R2]
      end
    end
  end

  // angle scaling pipeline
  assign mech_prod = raw_reg * MECH_SCALE;
  assign elec_prod = mech_reg * pp_reg;
  always_comb begin
    raw_next  = position_counter; // [R9]
    mech_next = 16'(mech_prod >> (qra_pkg::Q26_SHIFT - qra_pkg::Q15_SHIFT)) & qra_pkg::ANGLE_MASK; // [R11] [R13]
    elec_next = elec_prod[15:0] & qra_pkg::ANGLE_MASK; // [R12] [R13]
    dir_next  = ev.count_up ? qra_pkg::FLAG_SET : qra_pkg::FLAG_CLR; // [R14]
  end

  // apb slave, single-cycle access phase
  always_comb begin
    capctl_next  = capctl_reg;
    pp_next      = pp_reg;
    prdata_next  = prdata;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      pready_next = 1'b1;
      prdata_next = qra_pkg::DATA_ZERO;
      unique case (paddr)
        qra_pkg::ADDR_CAPCTL: prdata_next[15:0] = capctl_reg;
        qra_pkg::ADDR_TIMCON: prdata_next[qra_pkg::DIR_BIT] = ev.count_up; // [R5]
        qra_pkg::ADDR_CONFIG: prdata_next[qra_pkg::CFG_PP_LSB +: qra_pkg::CFG_PP_W] = pp_reg;
        qra_pkg::ADDR_COUNT:  prdata_next[CNT_W-1:0] = position_counter;
        qra_pkg::ADDR_IDXCNT: prdata_next[CNT_W-1:0] = idx_reg;
        qra_pkg::ADDR_THETA:  prdata_next = {elec_reg, mech_reg};
        qra_pkg::ADDR_FLAGS:  prdata_next[7:0] = {dir_reg, sync_reg};
        default:              pslverr_next = 1'b1;
      endcase
    end
    if (psel && penable && pready && pwrite && !pslverr) begin
      unique case (paddr)
        qra_pkg::ADDR_CAPCTL: capctl_next = pwdata[15:0];
        qra_pkg::ADDR_CONFIG: pp_next = pwdata[qra_pkg::CFG_PP_LSB +: qra_pkg::CFG_PP_W];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      capctl_reg       <= '0;
      pp_reg           <= qra_pkg::POLE_PAIRS_RST;
      position_counter <= '0; // [R17]
      idx_reg          <= '0; // [R17]
      sync_reg         <= qra_pkg::FLAG_CLR; // [R17]
      raw_reg          <= '0;
      mech_reg         <= '0;
      elec_reg         <= '0;
      dir_reg          <= qra_pkg::FLAG_CLR;
      prdata           <= '0;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
    end else if (ce) begin
      capctl_reg       <= capctl_next;
      pp_reg           <= pp_next;
      position_counter <= position_counter_next;
      idx_reg          <= idx_next;
      sync_reg         <= sync_next;
      raw_reg          <= raw_next;
      mech_reg         <= mech_next;
      elec_reg         <= elec_next;
      dir_reg          <= dir_next;
      prdata           <= prdata_next;
      pready           <= pready_next;
      pslverr          <= pslverr_next;
    end
  end

  assign theta_mech      = mech_reg;
  assign theta_elec      = elec_reg;
  assign dir_flag        = dir_reg;
  assign index_sync_flag = sync_reg;
  assign count_at_index  = idx_reg;
endmodule : qra_top
`default_nettype wire

// ==== testbench/qra_top_asserts.sv ====
// port assertions for the quadrature rotor angle block
`timescale 1ns/1ps
`default_nettype none
module qra_top_asserts #(
  parameter int CNT_W = 16
) (
  input wire logic             clock,
  input wire logic             nrst,
  input wire logic             ce,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             index_pin,
  input wire logic [15:0]      theta_mech,
  input wire logic [15:0]      theta_elec,
  input wire logic [3:0]       dir_flag,
  input wire logic [3:0]       index_sync_flag,
  input wire logic [CNT_W-1:0] count_at_index
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence idx_rise;
    ce && $rose(index_pin);
  endsequence
  sequence idx_recent;
    $past(index_pin) || $past(index_pin, 2) || $past(index_pin, 3);
  endsequence
  apb_answer_a: assert property (psel && !penable && ce |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  sync_set_a: assert property (idx_rise |-> ##[1:3] index_sync_flag == 4'hf) else $error("flag not set");
  sync_hold_a: assert property (index_sync_flag == 4'hf |=> $stable(index_sync_flag)) else $error("flag lost");
  sync_code_a: assert property (index_sync_flag inside {4'h0, 4'hf}) else $error("bad flag");
  dir_code_a: assert property (dir_flag inside {4'h0, 4'hf}) else $error("bad direction code");
  angle_range_a: assert property (!theta_mech[15] && !theta_elec[15]) else $error("angle out of range");
  idx_save_a: assert property ($changed(count_at_index) |-> idx_recent) else $error("saved count moved");
endmodule : qra_top_asserts
bind qra_top qra_top_asserts #(.CNT_W(CNT_W)) u_chk (.*);
`default_nettype wire

// ==== testbench/qra_encoder_model.sv ====
// incremental shaft encoder model with quadrature and index outputs
`timescale 1ns/1ps
`default_nettype none
module qra_encoder_model (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic step,
  input  wire logic up,
  input  wire logic idx_req,
  output logic      chan_a,
  output logic      chan_b,
  output logic      idx
);
  logic [1:0] ph_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ph_reg <= 2'h0;
      idx <= 1'b0;
    end else begin
      if (step) ph_reg <= up ? ph_reg + 2'h1 : ph_reg - 2'h1;
      idx <= idx_req;
    end
  end
  assign chan_a = ph_reg == 2'h1 || ph_reg == 2'h2; // a leads b when turning forward
  assign chan_b = ph_reg[1];
endmodule : qra_encoder_model
`default_nettype wire

// ==== testbench/qra_top_tb.sv ====
// self-checking bench for the quadrature rotor angle block
`timescale 1ns/1ps
`default_nettype none
module qra_top_tb;
  logic        clock = 1'b0, nrst = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        step = 1'b0, up = 1'b1, idx_req = 1'b0, pready, pslverr, qa, qb, qi, e;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] theta_mech, theta_elec, count_at_index;
  logic [3:0]  dir_flag, index_sync_flag;
  int          n_errors = 0, checks = 0;
  qra_encoder_model enc (.clock(clock), .nrst(nrst), .step(step), .up(up), .idx_req(idx_req),
    .chan_a(qa), .chan_b(qb), .idx(qi));
  qra_top DUT (.clock(clock), .nrst(nrst), .ce(ce), .quad_pin_first(qa), .quad_pin_second(qb),
    .index_pin(qi), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .theta_mech(theta_mech),
    .theta_elec(theta_elec), .dir_flag(dir_flag), .index_sync_flag(index_sync_flag),
    .count_at_index(count_at_index));
  initial begin
    forever #5 clock = ~clock;
  end
  task finish_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      n_errors++;
      finish_test();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  task mv(input logic u, input int n);
    repeat (n) begin
      up <= u; step <= 1'b1;
      @(posedge clock);
      step <= 1'b0;
      repeat (3) @(posedge clock);
    end
    repeat (6) @(posedge clock);
  endtask : mv
  function automatic logic [31:0] ang(input int raw, input int pp);
    int m;
    m = ((raw * qra_pkg::MECH_SCALE_Q26) >> 11) & 32'h7fff;
    return 32'(((m * pp) & 32'h7fff) << 16 | m);
  endfunction : ang
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    chk({28'h0, index_sync_flag}, 32'h0);
    chk({16'h0, count_at_index}, 32'h0);
    rd(qra_pkg::ADDR_COUNT, 32'h0);
    mv(1'b1, 3);
    rd(qra_pkg::ADDR_COUNT, 32'h0);
    apb(1'b1, qra_pkg::ADDR_CAPCTL, 32'h6000);
    apb(1'b1, qra_pkg::ADDR_CONFIG, 32'h3);
    mv(1'b1, 5);
    rd(qra_pkg::ADDR_COUNT, 32'h5);
    apb(1'b0, qra_pkg::ADDR_TIMCON, 32'h0);
    chk(r & 32'h4000, 32'h4000);
    chk({28'h0, dir_flag}, 32'hf);
    rd(qra_pkg::ADDR_THETA, ang(5, 3));
    chk({theta_elec, theta_mech}, ang(5, 3));
    mv(1'b0, 7);
    rd(qra_pkg::ADDR_COUNT, 32'd3998);
    apb(1'b0, qra_pkg::ADDR_TIMCON, 32'h0);
    chk(r & 32'h4000, 32'h0);
    chk({28'h0, dir_flag}, 32'h0);
    rd(qra_pkg::ADDR_THETA, ang(3998, 3));
    chk({theta_elec, theta_mech}, ang(3998, 3));
    idx_req <= 1'b1;
    repeat (2) @(posedge clock);
    idx_req <= 1'b0;
    repeat (6) @(posedge clock);
    chk({16'h0, count_at_index}, 32'd3998);
    chk({28'h0, index_sync_flag}, 32'hf);
    rd(qra_pkg::ADDR_COUNT, 32'h0);
    mv(1'b1, 2);
    rd(qra_pkg::ADDR_COUNT, 32'h2);
    rd(qra_pkg::ADDR_IDXCNT, 32'd3998);
    nrst <= 1'b0;
    @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    chk({28'h0, index_sync_flag}, 32'h0);
    chk({16'h0, count_at_index}, 32'h0);
    rd(qra_pkg::ADDR_COUNT, 32'h0);
    rd(qra_pkg::ADDR_CAPCTL, 32'h0);
    apb(1'b1, 8'h40, 32'h1);
    chk({31'h0, e}, 32'h1);
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    finish_test();
  end
endmodule : qra_top_tb
`default_nettype wire
